// file: src/sramc_pkg.sv
// Package for the host-side controller of the 4K x 4 asynchronous static memory
package sramc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  localparam int DEPTH  = 4096;
  localparam int CLK_PERIOD_NS = 10;
  // Times in ns, fastest grade
  localparam int T_READ_CYCLE_NS   = 35;
  localparam int T_ADDR_ACCESS_NS  = 35;
  localparam int T_SEL_ACCESS_NS   = 35;
  localparam int T_WRITE_PULSE_NS  = 30;
  localparam int T_SEL_TO_END_NS   = 30;
  localparam int T_DATA_SETUP_NS   = 20;
  localparam int T_WRITE_CYCLE_NS  = 35;
  localparam int T_OUT_OFF_NS      = 20;
  localparam int T_WE_TO_HIZ_NS    = 15;
  // Least times round up to whole cycles
  localparam int RD_CYC = (T_READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_CYC = (T_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CYC = (T_OUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIZ_CYC = (T_WE_TO_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WSET  = 3'b010,
    ST_WPULS = 3'b011,
    ST_WREC  = 3'b100,
    ST_TURN  = 3'b101
  } sramc_state_type;

  typedef struct packed {
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } sramc_req_type;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic                sel_n;
    logic                we_n;
    logic [DATA_W-1:0]   dout;
    logic [DATA_W-1:0]   doe_n;
  } sramc_pins_type;
endpackage

// file: src/sramc_host.sv
// Host-side controller that drives the 4K x 4 asynchronous static memory pins
`timescale 1ns/1ps
// Notes on behaviour
// - Write interval needs both strobes low; ends when either rises.
// - Host meets data setup and hold to the rising edge ending writes.
// - Host holds each read address at least 35 ns.
// - Host keeps write strobe low at least 30 ns.
// - Address stable no later than write strobe falling.
// - Address stable at least 30 ns before write interval ends.
// - Select low at least 30 ns before write strobe rises.
// - Write data valid at least 20 ns before write strobe rises.
// - Address may change right after write strobe rises; write cycle 35 ns.
module sramc_host #(
  parameter int ADDR_W = sramc_pkg::ADDR_W,
  parameter int DATA_W = sramc_pkg::DATA_W
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic              CLK_EN,
  input  wire logic              REQ_VALID,
  input  wire logic              REQ_WRITE,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_WDATA,
  output logic                   REQ_READY,
  output logic                   RSP_VALID,
  output logic      [DATA_W-1:0] RSP_RDATA,
  output logic      [ADDR_W-1:0] MEM_WORD_ADDRESS,
  output logic                   MEM_SELECT_N,
  output logic                   MEM_WRITE_N,
  input  wire logic [DATA_W-1:0] MEM_DATA_BUS_4BIT_I,
  output logic      [DATA_W-1:0] MEM_DATA_BUS_4BIT_O,
  output logic      [DATA_W-1:0] MEM_DATA_BUS_4BIT_OE_N
);
  // Strobe stays low for the pulse width and for turn-around plus data setup
  localparam int WP_MIN   = sramc_pkg::WP_CYC - 1;
  localparam int WP_SETUP = sramc_pkg::HIZ_CYC + sramc_pkg::DS_CYC - 1;
  localparam int WP_END   = (WP_SETUP > WP_MIN) ? WP_SETUP : WP_MIN;
  localparam int CNT_MAX  = (1 << sramc_pkg::CNT_W) - 1;

  // The storage organisation is fixed, so other widths cannot be served
  if (ADDR_W != sramc_pkg::ADDR_W || DATA_W != sramc_pkg::DATA_W) begin : g_bad_width
    $error("Width parameters must match the memory organisation");
  end
  // The read wait and the write pulse wait must fit the sequencing counter
  if (sramc_pkg::RD_CYC + 1 > CNT_MAX || WP_END > CNT_MAX) begin : g_bad_count
    $error("Timing counts exceed the sequencing counter");
  end
  // Driving at once after the strobe falls would fight the device
  if (sramc_pkg::HIZ_CYC < 1) begin : g_bad_turn
    $error("Bus turn-around needs at least one cycle");
  end

  localparam logic [3:0] RD_LAST  = 4'(sramc_pkg::RD_CYC + 1);
  localparam logic [3:0] DRV_AT   = 4'(sramc_pkg::HIZ_CYC - 1);
  localparam logic [3:0] WP_LAST  = 4'(WP_END);
  localparam logic [3:0] REC_LAST = 4'(sramc_pkg::WC_CYC - sramc_pkg::WP_CYC);
  localparam logic [3:0] OFF_LAST = 4'(sramc_pkg::OFF_CYC - 1);

  sramc_pkg::sramc_state_type state_q, state_d;
  logic [3:0]        cnt_q, cnt_d;
  sramc_pkg::sramc_req_type req_q;
  sramc_pkg::sramc_pins_type pins_q, pins_d;
  logic [DATA_W-1:0] din_s1_q, din_s2_q;
  logic              rsp_valid_q, rsp_valid_d;
  logic [DATA_W-1:0] rdata_q;
  logic              ready_q, ready_d;

  wire take_req  = ready_q && REQ_VALID;
  wire cnt_done_rd  = (cnt_q == RD_LAST);
  wire cnt_done_wp  = (cnt_q == WP_LAST);
  wire cnt_done_drv = (cnt_q == DRV_AT);
  wire cnt_done_rec = (cnt_q == REC_LAST);
  wire cnt_done_off = (cnt_q == OFF_LAST);
  wire [DATA_W-1:0] drive_off = {DATA_W{1'b1}};
  wire [DATA_W-1:0] drive_on  = {DATA_W{1'b0}};

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q + 4'h1;
    pins_d      = pins_q;
    rsp_valid_d = 1'b0;
    ready_d     = 1'b0;
    unique case (state_q)
      sramc_pkg::ST_IDLE: begin
        ready_d = 1'b1;
        cnt_d   = 4'h0;
        if (take_req) begin
          ready_d = 1'b0;
          pins_d.addr = REQ_ADDR;
          pins_d.sel_n = 1'b0;
          if (REQ_WRITE) begin
            state_d = sramc_pkg::ST_WSET;
          end else begin
            state_d = sramc_pkg::ST_READ;
          end
        end
      end
      sramc_pkg::ST_READ: begin
        if (cnt_done_rd) begin
          rsp_valid_d  = 1'b1;
          pins_d.sel_n = 1'b1;
          state_d      = sramc_pkg::ST_TURN;
          cnt_d        = 4'h0;
        end
      end
      sramc_pkg::ST_WSET: begin
        pins_d.we_n  = 1'b0;
        pins_d.dout  = req_q.wdata;
        state_d      = sramc_pkg::ST_WPULS;
        cnt_d        = 4'h0;
      end
      sramc_pkg::ST_WPULS: begin
        if (cnt_done_drv) begin
          pins_d.doe_n = drive_on;
        end
        if (cnt_done_wp) begin
          pins_d.we_n  = 1'b1;
          pins_d.sel_n = 1'b1;
          state_d      = sramc_pkg::ST_WREC;
          cnt_d        = 4'h0;
        end
      end
      sramc_pkg::ST_WREC: begin
        // data held past the rising edge
        if (cnt_done_rec) begin
          pins_d.doe_n = drive_off;
          state_d      = sramc_pkg::ST_TURN;
          cnt_d        = 4'h0;
        end
      end
      sramc_pkg::ST_TURN: begin
        if (cnt_done_off) begin
          state_d = sramc_pkg::ST_IDLE;
          ready_d = 1'b1;
        end
      end
      default: begin
        state_d = sramc_pkg::ST_IDLE;
        pins_d  = '{addr: '0, sel_n: 1'b1, we_n: 1'b1, dout: '0, doe_n: drive_off};
      end
    endcase
  end

  // Sequencer state; everything freezes while the clock enable is low
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_q     <= sramc_pkg::ST_IDLE;
      cnt_q       <= 4'h0;
      rsp_valid_q <= 1'b0;
      ready_q     <= 1'b0;
    end else if (CLK_EN) begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      rsp_valid_q <= rsp_valid_d;
      ready_q     <= ready_d;
    end
  end

  // Pins leave registers only, so no decode glitch reaches the memory
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pins_q <= '{addr: '0, sel_n: 1'b1, we_n: 1'b1, dout: '0, doe_n: 4'hF};
    end else if (CLK_EN) begin
      pins_q <= pins_d;
    end
  end

  // Two stages before use; the word taken is the bus sampled 40 ns after the address, 5 ns past access time
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      din_s1_q <= 4'h0;
      din_s2_q <= 4'h0;
    end else if (CLK_EN) begin
      din_s1_q <= MEM_DATA_BUS_4BIT_I;
      din_s2_q <= din_s1_q;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      req_q <= '0;
    end else if (CLK_EN && take_req) begin
      req_q <= '{write: REQ_WRITE, addr: REQ_ADDR, wdata: REQ_WDATA};
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= 4'h0;
    end else if (CLK_EN && rsp_valid_d) begin
      rdata_q <= din_s2_q;
    end
  end

  assign REQ_READY              = ready_q;
  assign RSP_VALID              = rsp_valid_q;
  assign RSP_RDATA              = rdata_q;
  assign MEM_WORD_ADDRESS       = pins_q.addr;
  assign MEM_SELECT_N           = pins_q.sel_n;
  assign MEM_WRITE_N            = pins_q.we_n;
  assign MEM_DATA_BUS_4BIT_O    = pins_q.dout;
  assign MEM_DATA_BUS_4BIT_OE_N = pins_q.doe_n;
endmodule

// file: testbench/sramc_host_sva.sv
// Pin timing checker for the host controller
`timescale 1ns/1ps
module sramc_host_sva (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        CLK_EN,
  input wire logic        REQ_VALID,
  input wire logic        REQ_WRITE,
  input wire logic        REQ_READY,
  input wire logic        RSP_VALID,
  input wire logic [11:0] MEM_WORD_ADDRESS,
  input wire logic        MEM_SELECT_N,
  input wire logic        MEM_WRITE_N,
  input wire logic [3:0]  MEM_DATA_BUS_4BIT_OE_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  property p_wp; $fell(MEM_WRITE_N) |-> !MEM_WRITE_N [*4] ##1 MEM_WRITE_N; endproperty
  a_wp: assert property (p_wp) else $error("strobe width");
  property p_rd; CLK_EN && REQ_VALID && REQ_READY && !REQ_WRITE |=> !RSP_VALID [*6] ##1 RSP_VALID;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer time");
  property p_sel; $fell(MEM_SELECT_N) |-> !MEM_SELECT_N [*4]; endproperty
  a_sel: assert property (p_sel) else $error("select too short");
  property p_adr; !MEM_SELECT_N && $past(!MEM_SELECT_N) |-> $stable(MEM_WORD_ADDRESS); endproperty
  a_adr: assert property (p_adr) else $error("address moved");
  property p_cw; $rose(MEM_WRITE_N) |-> $past(MEM_SELECT_N, 4) == 1'b0; endproperty
  a_cw: assert property (p_cw) else $error("select lead");
  property p_dw; $rose(MEM_WRITE_N) |-> $past(MEM_DATA_BUS_4BIT_OE_N, 2) == 4'h0; endproperty
  a_dw: assert property (p_dw) else $error("data setup");
  property p_dh;
    $rose(MEM_WRITE_N) |-> (MEM_DATA_BUS_4BIT_OE_N == 4'h0) [*2] ##1 &MEM_DATA_BUS_4BIT_OE_N;
  endproperty
  a_dh: assert property (p_dh) else $error("data hold");
  property p_hiz; $fell(MEM_WRITE_N) |-> &MEM_DATA_BUS_4BIT_OE_N ##1 &MEM_DATA_BUS_4BIT_OE_N;
  endproperty
  a_hiz: assert property (p_hiz) else $error("bus driven before device release");
  property p_end; $rose(MEM_WRITE_N) |-> $rose(MEM_SELECT_N); endproperty
  a_end: assert property (p_end) else $error("write end");
endmodule
bind sramc_host sramc_host_sva u_sva (
  .CORE_CLK              (CORE_CLK),
  .RESET                 (RESET),
  .CLK_EN                (CLK_EN),
  .REQ_VALID             (REQ_VALID),
  .REQ_WRITE             (REQ_WRITE),
  .REQ_READY             (REQ_READY),
  .RSP_VALID             (RSP_VALID),
  .MEM_WORD_ADDRESS      (MEM_WORD_ADDRESS),
  .MEM_SELECT_N          (MEM_SELECT_N),
  .MEM_WRITE_N           (MEM_WRITE_N),
  .MEM_DATA_BUS_4BIT_OE_N(MEM_DATA_BUS_4BIT_OE_N)
);

// file: testbench/sramc_mem_model.sv
// Behavioural 4K x 4 static memory
`timescale 1ns/1ps
module sramc_mem_model (
  input  wire logic [11:0] addr,
  input  wire logic        sel_n,
  input  wire logic        we_n,
  input  wire logic [3:0]  bus,
  output logic      [3:0]  dq,
  output logic             drive
);
  logic [3:0] mem [4096];
  wire        standby;
  initial dq = 4'h0;
  // standby after a long deselect, left at once on select
  assign #(35, 0) standby = sel_n;
  // drives only selected, awake and not writing
  assign drive = !sel_n && we_n && !standby;
  // old word 3 ns, then junk until access time
  always @(addr or sel_n) begin
    dq <= #3 ~dq;
    dq <= #35 mem[addr];
  end
  // latch bus while both strobes low
  always @(sel_n or we_n or addr or bus) begin
    if (!sel_n && !we_n) mem[addr] = bus;
  end
endmodule

// file: testbench/testbench.sv
// Testbench for the host controller
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, wr = 1'b0;
  logic        rdy, rsp, sel_n, we_n, dev_en;
  logic [11:0] adr = 12'h000, maddr;
  logic [3:0]  wd = 4'h0, rdata, o, oe_n, bus, dq;
  int          err_count = 0, n_compared = 0;
  sramc_host uut (.CORE_CLK(clk), .RESET(rst), .CLK_EN(1'b1), .REQ_VALID(vld),
    .REQ_WRITE(wr), .REQ_ADDR(adr), .REQ_WDATA(wd), .REQ_READY(rdy), .RSP_VALID(rsp),
    .RSP_RDATA(rdata), .MEM_WORD_ADDRESS(maddr), .MEM_SELECT_N(sel_n), .MEM_WRITE_N(we_n),
    .MEM_DATA_BUS_4BIT_I(bus), .MEM_DATA_BUS_4BIT_O(o), .MEM_DATA_BUS_4BIT_OE_N(oe_n));
  sramc_mem_model mem (.addr(maddr), .sel_n(sel_n), .we_n(we_n), .bus(bus), .dq(dq),
    .drive(dev_en));
  // A clash shows as unknown; a released bus shows junk, not the last word
  assign bus = !oe_n[0] ? (dev_en ? 4'hX : o) : (dev_en ? dq : ~dq);
  initial forever #5 clk = ~clk;
  task automatic chk(input string what, input logic [11:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] d, output int n);
    @(negedge clk);
    vld = 1'b1;
    wr = w;
    adr = a;
    wd = d;
    n = 0;
    while (rdy !== 1'b1 && n++ < 50) @(negedge clk);
    chk("ready", {11'h000, rdy}, 12'h001);
    @(negedge clk);
    vld = 1'b0;
    n = 0;
    while (!w && rsp !== 1'b1 && n++ < 20) @(negedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [3:0] exp);
    int n;
    xfer(1'b0, a, 4'h0, n);
    chk("latency", 12'(n), 12'h006);
    chk("rdata", {8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic t_corners;
    int n;
    logic [11:0] a [4] = '{12'h000, 12'hFFF, 12'h555, 12'hAAA};
    for (int i = 0; i < 4; i++) xfer(1'b1, a[i], 4'(i * 5 + 3), n);
    for (int i = 0; i < 4; i++) rd(a[i], 4'(i * 5 + 3));
  endtask
  task automatic t_overwrite;
    int n;
    rd(12'h555, 4'hD);
    xfer(1'b1, 12'h554, 4'hF, n);
    rd(12'h555, 4'hD);
    xfer(1'b1, 12'h555, 4'h0, n);
    rd(12'h555, 4'h0);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run is near 130 cycles; this leaves ample margin
  initial begin
    #200000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (8) @(negedge clk);
    chk("idle pins", {9'h000, sel_n, we_n, oe_n[0]}, 12'h007);
    rst = 1'b0;
    t_corners();
    t_overwrite();
    close_out();
  end
endmodule
